// >>> verilog/battery_status_and_charge_request.sv
// Status word, charge request words and alarm broadcast of the gas gauge
`timescale 1ns/1ps
`default_nettype none
module battery_status_and_charge_request (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [7:0] cmd_code,
	input wire logic cmd_read,
	input wire logic cmd_write,
	input wire logic cmd_bad_size,
	input wire logic cmd_reserved,
	input wire logic cmd_unsupported,
	input wire logic cmd_busy,
	input wire logic cmd_overflow,
	input wire logic cmd_unknown,
	input wire logic [15:0] desired_current,
	input wire logic [15:0] desired_voltage,
	input wire logic charger_off,
	input wire logic cv_mode,
	input wire logic cc_mode,
	input wire logic [15:0] avg_time_to_full_calc,
	input wire logic capacity_units_mode,
	input wire logic [15:0] remaining_mah,
	input wire logic [15:0] remaining_10mwh,
	input wire logic [15:0] capacity_alarm_threshold,
	input wire logic [15:0] minutes_current,
	input wire logic [15:0] minutes_power,
	input wire logic [15:0] time_alarm_threshold,
	input wire logic charging,
	input wire logic capacity_rising,
	input wire logic overcharge_limit_hit,
	input wire logic mah_tick,
	input wire logic charge_param_fault,
	input wire logic primary_termination,
	input wire logic temp_at_max,
	input wire logic [15:0] remaining_charge,
	input wire logic pack_at_terminate,
	input wire logic cell_undervoltage_flag,
	input wire logic flash_load_valid,
	input wire logic flash_load_bad,
	input wire logic [7:0] relative_charge_percent,
	input wire logic [7:0] fully_charged_clear_pct,
	input wire logic below_end_voltage_threshold_two,
	input wire logic below_overload_current,
	input wire logic [7:0] battery_low_pct,
	input wire logic alarm_send,
	output logic [15:0] read_data,
	output logic read_valid,
	output logic [15:0] alarm_broadcast,
	output logic alarm_valid
);
	logic over_charged;
	logic stop_charge;
	logic over_temp;
	logic stop_discharge;
	logic low_capacity;
	logic low_runtime;
	logic initialized;
	logic not_charging_flag;
	logic fully_charged;
	logic fully_discharged;
	logic [2:0] err_code;
	logic rest_done;
	logic [15:0] status_word;
	logic [15:0] capacity_now;
	logic [15:0] minutes_now;
	logic [15:0] next_current;
	logic [15:0] next_voltage;
	logic [15:0] next_read;

	rest_charge_meter u_rest (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.restart(charging),
		.mah_tick(mah_tick),
		.reached(rest_done)
	);

	// One basis choice shared by both low alarms, so they never disagree
	function automatic logic [15:0] pick_basis(
		input logic mode,
		input logic [15:0] charge_value,
		input logic [15:0] energy_value
	);
		pick_basis = mode ? energy_value : charge_value;
	endfunction : pick_basis

	// Mode bit picks charge or energy basis for the low alarms
	assign capacity_now = pick_basis(capacity_units_mode, remaining_mah,
		remaining_10mwh); // [RULE12]
	assign minutes_now = pick_basis(capacity_units_mode, minutes_current,
		minutes_power); // [RULE12]

	// Off wins over the cv_mode value; the voltage word ignores off
	always_comb
	begin
		if (charger_off)
			next_current = gauge_status_pkg::current_off; // [RULE1]
		else if (cv_mode)
			next_current = gauge_status_pkg::word_invalid; // [RULE2]
		else
			next_current = desired_current; // [RULE4]
		if (cc_mode)
			next_voltage = gauge_status_pkg::word_invalid; // [RULE3]
		else
			next_voltage = desired_voltage; // [RULE4]
	end

	// Hold until charging stops and 2 mAh of rest has passed
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			over_charged <= 1'b0;
		else if (overcharge_limit_hit)
			over_charged <= 1'b1; // [RULE13]
		else if (!charging && rest_done)
			over_charged <= 1'b0; // [RULE13]
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			stop_charge <= 1'b0;
		else if (charging && (charge_param_fault || primary_termination))
			stop_charge <= 1'b1; // [RULE14]
		else
			stop_charge <= 1'b0; // [RULE14]
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			over_temp <= 1'b0;
		else
			over_temp <= temp_at_max; // [RULE15]
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			stop_discharge <= 1'b0;
		else
			stop_discharge <= (remaining_charge == 16'h0000)
				|| pack_at_terminate || cell_undervoltage_flag; // [RULE16]
	end

	// Set below threshold; clear only on lowered threshold or charge gain
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			low_capacity <= 1'b0;
		else if (capacity_now < capacity_alarm_threshold)
			low_capacity <= 1'b1; // [RULE17]
		else if (capacity_rising || capacity_alarm_threshold < capacity_now)
			low_capacity <= 1'b0; // [RULE17]
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			low_runtime <= 1'b0;
		else if (!charging && minutes_now < time_alarm_threshold)
			low_runtime <= 1'b1; // [RULE18]
		else if (charging || time_alarm_threshold < minutes_now)
			low_runtime <= 1'b0; // [RULE18]
	end

	// Set wins if both loads are reported at once
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			initialized <= 1'b0;
		else if (flash_load_valid)
			initialized <= 1'b1; // [RULE19]
		else if (flash_load_bad)
			initialized <= 1'b0; // [RULE19]
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			not_charging_flag <= 1'b1;
		else
			not_charging_flag <= !charging; // [RULE20]
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			fully_charged <= 1'b0;
		else if (primary_termination || overcharge_limit_hit)
			fully_charged <= 1'b1; // [RULE21]
		else if (relative_charge_percent < fully_charged_clear_pct)
			fully_charged <= 1'b0; // [RULE21]
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			fully_discharged <= 1'b0;
		else if ((below_end_voltage_threshold_two && below_overload_current)
			|| relative_charge_percent < battery_low_pct)
			fully_discharged <= 1'b1; // [RULE22]
		else if (relative_charge_percent
			>= gauge_status_pkg::discharged_clear_pct)
			fully_discharged <= 1'b0; // [RULE22]
	end

	// Outcome of the last command; priority picks one code per command
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			err_code <= gauge_status_pkg::err_ok;
		else if (cmd_read || cmd_write)
		begin
			if (cmd_busy)
				err_code <= gauge_status_pkg::err_busy; // [RULE10]
			else if (cmd_reserved)
				err_code <= gauge_status_pkg::err_reserved; // [RULE9]
			else if (cmd_unsupported)
				err_code <= gauge_status_pkg::err_unsupported; // [RULE9]
			else if (cmd_write && cmd_bad_size)
				err_code <= gauge_status_pkg::err_bad_size; // [RULE9]
			else if (cmd_write)
				err_code <= gauge_status_pkg::err_access_denied; // [RULE9]
			else if (cmd_overflow)
				err_code <= gauge_status_pkg::err_overflow; // [RULE10]
			else if (cmd_unknown)
				err_code <= gauge_status_pkg::err_unknown; // [RULE8]
			else
				err_code <= gauge_status_pkg::err_ok; // [RULE8]
		end
	end

	// Reserved positions stay zero
	always_comb
	begin
		status_word = gauge_status_pkg::status_reset; // [RULE24]
		status_word[gauge_status_pkg::bit_over_charged] = over_charged; // [RULE6]
		status_word[gauge_status_pkg::bit_stop_charge] = stop_charge; // [RULE6]
		status_word[gauge_status_pkg::bit_over_temp] = over_temp; // [RULE6]
		status_word[gauge_status_pkg::bit_stop_discharge] = stop_discharge;
		status_word[gauge_status_pkg::bit_low_capacity] = low_capacity;
		status_word[gauge_status_pkg::bit_low_runtime] = low_runtime; // [RULE6]
		status_word[gauge_status_pkg::bit_initialized] = initialized; // [RULE7]
		status_word[gauge_status_pkg::bit_not_charging] = not_charging_flag;
		status_word[gauge_status_pkg::bit_fully_charged] = fully_charged;
		status_word[gauge_status_pkg::bit_fully_discharged] =
			fully_discharged; // [RULE7]
		status_word[2:0] = err_code; // [RULE8]
	end

	always_comb
	begin
		unique case (cmd_code)
			gauge_status_pkg::cmd_time_to_full:
				next_read = not_charging_flag ? gauge_status_pkg::word_invalid
					: avg_time_to_full_calc; // [RULE23]
			gauge_status_pkg::cmd_charge_current:
				next_read = next_current;
			gauge_status_pkg::cmd_charge_voltage:
				next_read = next_voltage;
			gauge_status_pkg::cmd_status_word:
				next_read = status_word;
			default:
				next_read = gauge_status_pkg::status_reset;
		endcase
	end

	// Word is sampled at the read strobe, so the host sees a stable value
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			read_data <= gauge_status_pkg::status_reset;
			read_valid <= 1'b0;
		end
		else
		begin
			read_valid <= cmd_read;
			if (cmd_read)
				read_data <= next_read; // [RULE4]
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			alarm_broadcast <= gauge_status_pkg::status_reset;
			alarm_valid <= 1'b0;
		end
		else
		begin
			alarm_valid <= alarm_send;
			if (alarm_send)
				alarm_broadcast <= {status_word[15:3],
					gauge_status_pkg::err_all_ones}; // [RULE11]
		end
	end
endmodule : battery_status_and_charge_request
`default_nettype wire

// >>> verilog/gauge_status_pkg.sv
// Constants for the battery status and charge request word block
// Overview of operation
// RULE1 - A charge current request of zero switches the external charger off.
// RULE2 - Current request 65535 asks the charger to act as a voltage source.
// RULE3 - Voltage request 65535 asks the charger to act as a current source.
// RULE4 - Both request words are unsigned 16-bit reads, 1 mA and 1 mV steps.
// RULE5 - The charger should use current and voltage requests together.
// RULE6 - Alarm flags sit at bits 15,14,12,11,9,8; bits 13 and 10 reserved.
// RULE7 - Status flags sit at bits 7,6,5,4 of the status word.
// RULE8 - Low three bits hold the error code of the last command.
// RULE9 - Codes: 4 read-only write, 6 bad size, 3 unsupported, 2 reserved.
// RULE10 - Code 1 when busy, code 5 on data overflow or underflow.
// RULE11 - Alarm broadcast sends the status word with error bits all ones.
// RULE12 - Low capacity and low runtime use charge or energy per mode bit.
// RULE13 - Overcharge sets past limit, clears after stop plus 2 mAh rest.
// RULE14 - Stop-charge sets on range fault or termination, clears when gone.
// RULE15 - Over-temperature follows temperature against the maximum threshold.
// RULE16 - Stop-discharge sets on empty, low voltage or cell undervoltage.
// RULE17 - Low-capacity sets below threshold, clears when threshold or charge.
// RULE18 - Low-runtime sets below time threshold, clears likewise.
// RULE19 - Initialized sets on valid flash load, clears on improper load.
// RULE20 - Not-charging flag follows whether the battery is being charged.
// RULE21 - Fully charged sets on termination or overcharge, clears below limit.
// RULE22 - Fully discharged sets on low voltage or charge, clears at 20 percent.
// RULE23 - Time to full reads 65535 whenever the battery is not charging.
// RULE24 - Reserved status word bits read as zero.
package gauge_status_pkg;
	localparam logic [7:0] cmd_time_to_full = 8'h13;
	localparam logic [7:0] cmd_charge_current = 8'h14;
	localparam logic [7:0] cmd_charge_voltage = 8'h15;
	localparam logic [7:0] cmd_status_word = 8'h16;
	localparam logic [15:0] word_invalid = 16'hFFFF;
	localparam logic [15:0] current_off = 16'h0000;
	localparam int bit_over_charged = 15;
	localparam int bit_stop_charge = 14;
	localparam int bit_over_temp = 12;
	localparam int bit_stop_discharge = 11;
	localparam int bit_low_capacity = 9;
	localparam int bit_low_runtime = 8;
	localparam int bit_initialized = 7;
	localparam int bit_not_charging = 6;
	localparam int bit_fully_charged = 5;
	localparam int bit_fully_discharged = 4;
	localparam logic [2:0] err_ok = 3'h0;
	localparam logic [2:0] err_busy = 3'h1;
	localparam logic [2:0] err_reserved = 3'h2;
	localparam logic [2:0] err_unsupported = 3'h3;
	localparam logic [2:0] err_access_denied = 3'h4;
	localparam logic [2:0] err_overflow = 3'h5;
	localparam logic [2:0] err_bad_size = 3'h6;
	localparam logic [2:0] err_unknown = 3'h7;
	localparam logic [2:0] err_all_ones = 3'h7;
	localparam logic [15:0] status_reset = 16'h0000;
	localparam logic [15:0] rest_charge_limit = 16'h0002;
	localparam logic [7:0] discharged_clear_pct = 8'h14;
	localparam logic [15:0] rest_reset = 16'h0000;
endpackage : gauge_status_pkg

// >>> verilog/rest_charge_meter.sv
// Accumulator of rest or discharge charge after charging stops
`timescale 1ns/1ps
`default_nettype none
module rest_charge_meter (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic restart,
	input wire logic mah_tick,
	output logic reached
);
	logic [15:0] count;

	// Any charging restarts the run so the rest must be continuous
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			count <= gauge_status_pkg::rest_reset;
		else if (restart)
			count <= gauge_status_pkg::rest_reset;
		else if (mah_tick && !reached)
			count <= 16'(count + 16'h0001);
	end

	assign reached = (count >= gauge_status_pkg::rest_charge_limit); // [RULE13]
endmodule : rest_charge_meter
`default_nettype wire

// >>> tb/status_request_assertions.sv
// Checker for the status and charge request block
`timescale 1ns/1ps
`default_nettype none
module status_request_checker (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [7:0] cmd_code,
	input wire logic cmd_read,
	input wire logic [15:0] desired_current,
	input wire logic charger_off,
	input wire logic cv_mode,
	input wire logic cc_mode,
	input wire logic alarm_send,
	input wire logic [15:0] read_data,
	input wire logic read_valid,
	input wire logic [15:0] alarm_broadcast,
	input wire logic alarm_valid
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	logic rq_cur;
	assign rq_cur = cmd_read && cmd_code == 8'h14;
	property p_rd_ans; cmd_read |=> read_valid; endproperty
	a_rd_ans: assert property (p_rd_ans) else $error("read unanswered");
	property p_rd_idle; !cmd_read |=> !read_valid; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("stray read");
	property p_cur; rq_cur && !charger_off && !cv_mode
		|=> read_data == $past(desired_current); endproperty
	a_cur: assert property (p_cur) else $error("current word");
	property p_off; rq_cur && charger_off |=> read_data == 16'h0000; endproperty
	a_off: assert property (p_off) else $error("charger not off");
	property p_cv; rq_cur && cv_mode && !charger_off
		|=> read_data == 16'hFFFF; endproperty
	a_cv: assert property (p_cv) else $error("cv request");
	property p_cc; cmd_read && cmd_code == 8'h15 && cc_mode
		|=> read_data == 16'hFFFF; endproperty
	a_cc: assert property (p_cc) else $error("cc request");
	property p_al_ans; alarm_send |=> alarm_valid; endproperty
	a_al_ans: assert property (p_al_ans) else $error("no alarm");
	property p_al_err; alarm_valid |-> alarm_broadcast[2:0] == 3'h7; endproperty
	a_al_err: assert property (p_al_err) else $error("alarm code");
	property p_rsvd; alarm_valid |-> alarm_broadcast[13] == 1'b0
		&& alarm_broadcast[10] == 1'b0 && alarm_broadcast[3] == 1'b0; endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
	c_status: cover property (cmd_read && cmd_code == 8'h16);
	c_alarm: cover property (alarm_valid);
	c_cv: cover property (rq_cur && cv_mode);
endmodule : status_request_checker
bind battery_status_and_charge_request status_request_checker
	status_request_checker_inst (.ref_clk, .rst_n, .cmd_code, .cmd_read,
	.desired_current, .charger_off, .cv_mode, .cc_mode, .alarm_send,
	.read_data, .read_valid, .alarm_broadcast, .alarm_valid);
`default_nettype wire

// >>> tb/charger_model.sv
// Charger side model acting on the request words it reads
`timescale 1ns/1ps
`default_nettype none
module charger_model (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [7:0] cmd_code,
	input wire logic read_valid,
	input wire logic [15:0] read_data,
	output logic charger_on,
	output logic voltage_source,
	output logic current_source
);
	logic [15:0] amps;
	logic [15:0] volts;
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			amps <= 16'h0000;
			volts <= 16'h0000;
		end
		else if (read_valid && cmd_code == 8'h14)
			amps <= read_data;
		else if (read_valid && cmd_code == 8'h15)
			volts <= read_data;
	end
	// Both words must be nonzero to switch on; each source mode follows one word alone
	assign charger_on = amps != 16'h0000 && volts != 16'h0000;
	assign voltage_source = amps == 16'hFFFF;
	assign current_source = volts == 16'hFFFF;
endmodule : charger_model
`default_nettype wire

// >>> tb/testbench.sv
// Self-checking testbench for the status and charge request block
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic ref_clk, rst_n, cmd_read, cmd_write, mah_tick, flash_load_valid;
	logic flash_load_bad, alarm_send, read_valid, alarm_valid, charger_on;
	logic voltage_source, current_source;
	logic [7:0] cmd_code, relative_charge_percent;
	logic [15:0] desired_current, desired_voltage, remaining_mah;
	logic [15:0] remaining_10mwh, capacity_alarm_threshold, minutes_current;
	logic [15:0] time_alarm_threshold, remaining_charge, read_data;
	logic [15:0] alarm_broadcast;
	logic [13:0] lv;
	logic [5:0] qual;
	wire logic charger_off, cv_mode, cc_mode, capacity_units_mode, charging;
	wire logic capacity_rising, overcharge_limit_hit, charge_param_fault;
	wire logic primary_termination, temp_at_max, pack_at_terminate;
	wire logic cell_undervoltage_flag, below_end_voltage_threshold_two;
	wire logic below_overload_current, cmd_bad_size, cmd_reserved;
	wire logic cmd_unsupported, cmd_busy, cmd_overflow, cmd_unknown;
	int n_mismatch, cmp_count;
	assign {below_overload_current, below_end_voltage_threshold_two,
		cell_undervoltage_flag, pack_at_terminate, temp_at_max,
		primary_termination, charge_param_fault, overcharge_limit_hit,
		capacity_rising, charging, capacity_units_mode, cc_mode, cv_mode,
		charger_off} = lv;
	assign {cmd_unknown, cmd_overflow, cmd_busy, cmd_unsupported,
		cmd_reserved, cmd_bad_size} = qual;
	battery_status_and_charge_request battery_status_and_charge_request_inst (
		.ref_clk, .rst_n, .cmd_code, .cmd_read, .cmd_write, .cmd_bad_size,
		.cmd_reserved, .cmd_unsupported, .cmd_busy, .cmd_overflow, .cmd_unknown,
		.desired_current, .desired_voltage, .charger_off, .cv_mode, .cc_mode,
		.avg_time_to_full_calc(16'h0100), .capacity_units_mode, .remaining_mah,
		.remaining_10mwh, .capacity_alarm_threshold, .minutes_current,
		.minutes_power(16'h01F4), .time_alarm_threshold, .charging,
		.capacity_rising, .overcharge_limit_hit, .mah_tick, .charge_param_fault,
		.primary_termination, .temp_at_max, .remaining_charge,
		.pack_at_terminate, .cell_undervoltage_flag, .flash_load_valid,
		.flash_load_bad, .relative_charge_percent,
		.fully_charged_clear_pct(8'h28), .below_end_voltage_threshold_two,
		.below_overload_current, .battery_low_pct(8'h0A), .alarm_send,
		.read_data, .read_valid, .alarm_broadcast, .alarm_valid);
	charger_model charger_model_inst (.ref_clk, .rst_n, .cmd_code, .read_valid,
		.read_data, .charger_on, .voltage_source, .current_source);
	task end_of_test();
		if (n_mismatch == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_of_test
	task cmp(input string what, input logic [15:0] exp, got);
		cmp_count++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp
	// Answer lands at the taking edge, exactly one cycle after the request is raised
	task rd(input logic [7:0] code, input logic [15:0] mask, exp);
		@(posedge ref_clk) #1;
		{cmd_code, cmd_read} = {code, 1'b1};
		@(posedge ref_clk) #1;
		cmd_read = 1'b0;
		cmp("read_valid", 16'h0001, {15'h0, read_valid});
		cmp("read_data", exp, read_data & mask);
	endtask : rd
	// Status read reports the command before it
	task err(input logic w, input logic [5:0] q, input logic [15:0] exp);
		@(posedge ref_clk) #1;
		{cmd_code, cmd_write, cmd_read, qual} = {8'h16, w, !w, q};
		@(posedge ref_clk) #1;
		{cmd_write, cmd_read, qual} = 8'h00;
		rd(8'h16, 16'h0007, exp);
	endtask : err
	initial
	begin
		ref_clk = 1'b0;
		forever #25 ref_clk = !ref_clk;
	end
	initial
	begin
		n_mismatch = 0;
		cmp_count = 0;
		{rst_n, lv, qual} = 21'h000000;
		{cmd_read, cmd_write, mah_tick, flash_load_valid} = 4'h0;
		{flash_load_bad, alarm_send, cmd_code} = 10'h000;
		{desired_current, desired_voltage} = {16'h1234, 16'h4321};
		{remaining_mah, remaining_10mwh} = {16'h03E8, 16'h0032};
		{capacity_alarm_threshold, minutes_current} = {16'h0064, 16'h01F4};
		{time_alarm_threshold, remaining_charge} = {16'h000A, 16'h0100};
		relative_charge_percent = 8'h32;
		repeat (2) @(posedge ref_clk);
		#1 rst_n = 1'b1;
		rd(8'h16, 16'hFFFF, 16'h0040);
		rd(8'h14, 16'hFFFF, 16'h1234);
		rd(8'h15, 16'hFFFF, 16'h4321);
		@(posedge ref_clk) #1;
		cmp("charger_on", 16'h0001, {15'h0, charger_on});
		lv = 14'h0001;
		rd(8'h14, 16'hFFFF, 16'h0000);
		@(posedge ref_clk) #1;
		cmp("charger_on", 16'h0000, {15'h0, charger_on});
		lv = 14'h0002;
		rd(8'h14, 16'hFFFF, 16'hFFFF);
		@(posedge ref_clk) #1;
		cmp("voltage_source", 16'h0001, {15'h0, voltage_source});
		lv = 14'h0003;
		rd(8'h14, 16'hFFFF, 16'h0000);
		lv = 14'h0004;
		rd(8'h15, 16'hFFFF, 16'hFFFF);
		@(posedge ref_clk) #1;
		cmp("current_source", 16'h0001, {15'h0, current_source});
		rd(8'h14, 16'hFFFF, 16'h1234);
		rd(8'h13, 16'hFFFF, 16'hFFFF);
		rd(8'h30, 16'hFFFF, 16'h0000);
		{lv, relative_charge_percent, flash_load_valid} = {14'h0A08, 8'h05, 1'b1};
		@(posedge ref_clk) #1;
		flash_load_valid = 1'b0;
		rd(8'h16, 16'hFFF8, 16'h1AD0);
		@(posedge ref_clk) #1;
		alarm_send = 1'b1;
		@(posedge ref_clk) #1;
		alarm_send = 1'b0;
		cmp("alarm_word", 16'h1AD7, alarm_broadcast);
		cmp("alarm_valid", 16'h0001, {15'h0, alarm_valid});
		{lv, relative_charge_percent, flash_load_bad} = {14'h01D8, 8'h32, 1'b1};
		capacity_alarm_threshold = 16'h0010;
		@(posedge ref_clk) #1;
		flash_load_bad = 1'b0;
		rd(8'h16, 16'hFFF8, 16'hC020);
		rd(8'h13, 16'hFFFF, 16'h0100);
		lv = 14'h0000;
		for (int k = 0; k < 2; k++)
		begin
			mah_tick = 1'b1;
			@(posedge ref_clk) #1;
			mah_tick = 1'b0;
			rd(8'h16, 16'hFFF8, k ? 16'h0060 : 16'h8060);
		end
		{relative_charge_percent, minutes_current} = {8'h1E, 16'h0005};
		remaining_charge = 16'h0000;
		rd(8'h16, 16'hFFF8, 16'h0940);
		lv = 14'h3000;
		rd(8'h16, 16'hFFF8, 16'h0950);
		err(1'b0, 6'h00, 16'h0000);
		err(1'b1, 6'h00, 16'h0004);
		err(1'b1, 6'h01, 16'h0006);
		err(1'b0, 6'h04, 16'h0003);
		err(1'b0, 6'h02, 16'h0002);
		err(1'b0, 6'h08, 16'h0001);
		err(1'b0, 6'h10, 16'h0005);
		err(1'b0, 6'h20, 16'h0007);
		err(1'b1, 6'h3F, 16'h0001);
		end_of_test();
	end
endmodule : testbench
`default_nettype wire
